// ---- shared/uart_irq_pkg.sv ----
// package for the dual serial interrupt control block
// functional notes list, register offsets, field positions, reset values
// assumes a byte-wide register port clocked by sys_clk at 10 MHz
//
// Functional notes
// - read 0E starts counter, no data driven
// - write 0E sets output bits where one
// - output pins drive inverse of bits
// - irq_n can fire on any event
// - status 05 read, mask 05 write, masked 02
// - status bit layout fixed, seven down to zero
// - input change sets bit 7, change read clears
// - channel B break change sets, command clears
// - receive-ready mode tracks FIFO not empty
// - FIFO-full mode sets on fill only
// - bit 4 mirrors channel B transmit ready
// - transmit ready follows enable, disabled writes dropped
// - timer mode sets once per square wave
// - counter mode sets at zero, stop halts
// - channel A bits behave like channel B
// - masked status is status AND mask
// - mask one enables, FF enables all
`default_nettype none

package uart_irq_pkg;

    // =========================================================
    // register offsets
    localparam logic [3:0] ADDR_MASKED_STATUS = 4'h2;
    localparam logic [3:0] ADDR_STATUS_MASK = 4'h5;
    localparam logic [3:0] ADDR_VECTOR = 4'hC;
    localparam logic [3:0] ADDR_COMMAND_PORT = 4'hE;
    localparam logic [3:0] ADDR_PIN_SELECT = 4'hD;
    localparam logic [3:0] ADDR_EVT_ENABLE = 4'h8;
    localparam logic [3:0] ADDR_EVT_CLEAR = 4'h9;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'hA;

    // =========================================================
    // status bit positions
    localparam int BIT_TX_A = 0;
    localparam int BIT_RX_A = 1;
    localparam int BIT_BRK_A = 2;
    localparam int BIT_COUNTER = 3;
    localparam int BIT_TX_B = 4;
    localparam int BIT_RX_B = 5;
    localparam int BIT_BRK_B = 6;
    localparam int BIT_INPUT = 7;

    // =========================================================
    // reset values
    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [7:0] RESET_VECTOR = 8'h0F;
    localparam logic [7:0] RESET_OUTPUT = 8'h00;
    localparam logic [3:0] RESET_PIN_SELECT = 4'h0;
    localparam logic [2:0] RESET_EVT = 3'h0;

    // counter state
    typedef enum logic [1:0] {CT_IDLE, CT_RUN, CT_DONE} counter_state_t;

endpackage : uart_irq_pkg

`default_nettype wire

// ---- core/rx_flag_cell.sv ----
// one receive-ready or FIFO-full status cell for one channel
// assumes fifo level and event strobes come from the channel receiver
`default_nettype none

module rx_flag_cell
    import uart_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic fullMode,
    input wire logic loadStrobe,
    input wire logic fifoFull,
    input wire logic fifoNotEmpty,
    input wire logic popStrobe,
    output logic flag
);

    // =========================================================
    // set and clear terms
    wire logic setReady;
    wire logic setFull;
    wire logic next_flag;

    assign setReady = !fullMode && (loadStrobe || (popStrobe && fifoNotEmpty));
    assign setFull = fullMode && loadStrobe && fifoFull;
    // set wins over the pop clear
    assign next_flag = (setReady || setFull) ? 1'b1 : (popStrobe ? 1'b0 : flag);

    // flag register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end

    // =========================================================
    // checks
    pop_clears_a: assert property (@(posedge sys_clk) disable iff (rst)
        popStrobe && !loadStrobe && !(fifoNotEmpty && !fullMode) |=> !flag)
        else $error("receive flag not cleared by pop");
    full_sets_a: assert property (@(posedge sys_clk) disable iff (rst)
        fullMode && loadStrobe && fifoFull |=> flag)
        else $error("fifo full flag not set");

endmodule // rx_flag_cell

`default_nettype wire

// ---- core/uart_irq_ctrl.sv ----
// interrupt control and address-triggered commands of a dual serial block
// assumes a single-cycle register port and event strobes from the channels
`default_nettype none

module uart_irq_ctrl
    import uart_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // input pins 0 to 3
    input wire logic [3:0] inputPins,
    // channel A events
    input wire logic breakEdgeA,
    input wire logic resetBreakA,
    input wire logic rxFullModeA,
    input wire logic rxLoadA,
    input wire logic rxFifoFullA,
    input wire logic rxNotEmptyA,
    input wire logic rxPopA,
    input wire logic txEnableA,
    input wire logic txHoldWriteA,
    input wire logic txShiftLoadA,
    // channel B events
    input wire logic breakEdgeB,
    input wire logic resetBreakB,
    input wire logic rxFullModeB,
    input wire logic rxLoadB,
    input wire logic rxFifoFullB,
    input wire logic rxNotEmptyB,
    input wire logic rxPopB,
    input wire logic txEnableB,
    input wire logic txHoldWriteB,
    input wire logic txShiftLoadB,
    // counter/timer
    input wire logic timerMode,
    input wire logic counterZero,
    input wire logic squareWaveCycle,
    input wire logic stopCounter,
    input wire logic readInputChange,
    output logic counterRun,
    output logic counterStart,
    // pins and interrupts
    output logic [7:0] outputPins,
    output logic irq_n,
    output logic eventIrq,
    output logic txAcceptA,
    output logic txAcceptB
);

    // =========================================================
    // address decode
    wire logic rdStatus;
    wire logic wrMask;
    wire logic rdMasked;
    wire logic rdVector;
    wire logic wrVector;
    wire logic rdCommand;
    wire logic wrCommand;
    wire logic rdPinSel;
    wire logic wrPinSel;
    wire logic wrEvtEnable;
    wire logic wrEvtClear;
    wire logic rdEvtStatus;
    wire logic rdEvtEnable;

    assign rdStatus = regRead && regAddr == ADDR_STATUS_MASK;
    assign wrMask = regWrite && regAddr == ADDR_STATUS_MASK;
    assign rdMasked = regRead && regAddr == ADDR_MASKED_STATUS;
    assign rdVector = regRead && regAddr == ADDR_VECTOR;
    assign wrVector = regWrite && regAddr == ADDR_VECTOR;
    assign rdCommand = regRead && regAddr == ADDR_COMMAND_PORT;
    assign wrCommand = regWrite && regAddr == ADDR_COMMAND_PORT;
    assign rdPinSel = regRead && regAddr == ADDR_PIN_SELECT;
    assign wrPinSel = regWrite && regAddr == ADDR_PIN_SELECT;
    assign wrEvtEnable = regWrite && regAddr == ADDR_EVT_ENABLE;
    assign wrEvtClear = regWrite && regAddr == ADDR_EVT_CLEAR;
    assign rdEvtStatus = regRead && regAddr == ADDR_EVT_STATUS;
    assign rdEvtEnable = regRead && regAddr == ADDR_EVT_ENABLE;

    // =========================================================
    // software registers
    logic [7:0] interrupt_mask;
    logic [7:0] interrupt_vector;
    logic [7:0] output_port_bits;
    logic [3:0] auxiliary_control;

    // mask, vector, pin select and set-only output bits
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            interrupt_mask <= RESET_MASK;
            interrupt_vector <= RESET_VECTOR;
            output_port_bits <= RESET_OUTPUT;
            auxiliary_control <= RESET_PIN_SELECT;
        end
        else
        begin
            if (wrMask)
                interrupt_mask <= regWrData;
            if (wrVector)
                interrupt_vector <= regWrData;
            if (wrCommand)
                output_port_bits <= output_port_bits | regWrData;
            if (wrPinSel)
                auxiliary_control <= regWrData[3:0];
        end
    end

    assign outputPins = ~output_port_bits;

    // =========================================================
    // input change detection on selected pins
    logic [3:0] pinsLast;
    logic inputChange;
    wire logic pinEdge;

    assign pinEdge = |((inputPins ^ pinsLast) & auxiliary_control);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pinsLast <= 4'h0;
            inputChange <= 1'b0;
        end
        else
        begin
            pinsLast <= inputPins;
            if (pinEdge)
                inputChange <= 1'b1;
            else if (readInputChange)
                inputChange <= 1'b0;
        end
    end

    // =========================================================
    // break change flags
    logic breakFlagA;
    logic breakFlagB;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            breakFlagA <= 1'b0;
            breakFlagB <= 1'b0;
        end
        else
        begin
            breakFlagA <= breakEdgeA || (breakFlagA && !resetBreakA);
            breakFlagB <= breakEdgeB || (breakFlagB && !resetBreakB);
        end
    end

    // =========================================================
    // receive flags, one cell per channel
    logic rxFlagA;
    logic rxFlagB;

    rx_flag_cell rxCellA (
        .sys_clk(sys_clk),
        .rst(rst),
        .fullMode(rxFullModeA),
        .loadStrobe(rxLoadA),
        .fifoFull(rxFifoFullA),
        .fifoNotEmpty(rxNotEmptyA),
        .popStrobe(rxPopA),
        .flag(rxFlagA)
    );
    rx_flag_cell rxCellB (
        .sys_clk(sys_clk),
        .rst(rst),
        .fullMode(rxFullModeB),
        .loadStrobe(rxLoadB),
        .fifoFull(rxFifoFullB),
        .fifoNotEmpty(rxNotEmptyB),
        .popStrobe(rxPopB),
        .flag(rxFlagB)
    );

    // =========================================================
    // transmit ready flags
    logic txReadyA;
    logic txReadyB;
    logic txEnLastA;
    logic txEnLastB;

    // holding writes count only while enabled
    assign txAcceptA = txHoldWriteA && txEnableA;
    assign txAcceptB = txHoldWriteB && txEnableB;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            txReadyA <= 1'b0;
            txReadyB <= 1'b0;
            txEnLastA <= 1'b0;
            txEnLastB <= 1'b0;
        end
        else
        begin
            txEnLastA <= txEnableA;
            txEnLastB <= txEnableB;
            if (!txEnableA)
                txReadyA <= 1'b0;
            else if (!txEnLastA || txShiftLoadA)
                txReadyA <= 1'b1;
            else if (txAcceptA)
                txReadyA <= 1'b0;
            if (!txEnableB)
                txReadyB <= 1'b0;
            else if (!txEnLastB || txShiftLoadB)
                txReadyB <= 1'b1;
            else if (txAcceptB)
                txReadyB <= 1'b0;
        end
    end

    // =========================================================
    // counter ready and counter run control
    counter_state_t ctState;
    logic counterReady;
    wire logic ctSet;

    assign ctSet = timerMode ? squareWaveCycle : (counterRun && counterZero);
    assign counterStart = rdCommand;
    assign counterRun = (ctState == CT_RUN);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            counterReady <= 1'b0;
        else if (ctSet)
            counterReady <= 1'b1;
        else if (stopCounter)
            counterReady <= 1'b0;
    end

    // counter halts on stop only in counter mode
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ctState <= CT_IDLE;
        else
        begin
            unique case (ctState)
                CT_IDLE: if (rdCommand) ctState <= CT_RUN;
                CT_RUN: if (stopCounter && !timerMode) ctState <= CT_DONE;
                CT_DONE: ctState <= rdCommand ? CT_RUN : CT_IDLE;
                default: ctState <= CT_IDLE;
            endcase
        end
    end

    // =========================================================
    // status, masked status, interrupt
    wire logic [7:0] interrupt_status;
    wire logic [7:0] masked_interrupt_status;

    assign interrupt_status = {inputChange, breakFlagB, rxFlagB, txReadyB,
        counterReady, breakFlagA, rxFlagA, txReadyA};
    assign masked_interrupt_status = interrupt_status & interrupt_mask;
    assign irq_n = ~|masked_interrupt_status;

    // =========================================================
    // local event interrupt: status, enable, write-one clear
    logic [2:0] evtStatus;
    logic [2:0] evtEnable;
    logic irqLast;
    wire logic [2:0] evtSet;

    assign evtSet = {stopCounter, ~irq_n & irqLast, wrCommand};
    assign eventIrq = |(evtStatus & evtEnable);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            evtStatus <= RESET_EVT;
            evtEnable <= RESET_EVT;
            irqLast <= 1'b1;
        end
        else
        begin
            irqLast <= irq_n;
            evtStatus <= evtSet | (evtStatus & ~(wrEvtClear ? regWrData[2:0] : 3'h0));
            if (wrEvtEnable)
                evtEnable <= regWrData[2:0];
        end
    end

    // =========================================================
    // read data, one cycle after the strobe
    wire logic [7:0] rdMux;

    assign rdMux = rdStatus ? interrupt_status :
        rdMasked ? masked_interrupt_status :
        rdVector ? interrupt_vector :
        rdPinSel ? {4'h0, auxiliary_control} :
        rdEvtStatus ? {5'h00, evtStatus} :
        rdEvtEnable ? {5'h00, evtEnable} : 8'h00;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            regRdData <= 8'h00;
        else
            regRdData <= regRead ? rdMux : 8'h00;
    end

    // =========================================================
    // checks
    cmd_read_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        rdCommand |=> regRdData == 8'h00)
        else $error("command read drove data");
    set_bits_a: assert property (@(posedge sys_clk) disable iff (rst)
        wrCommand |=> output_port_bits == ($past(output_port_bits) | $past(regWrData)))
        else $error("output bits not or-set");
    pins_inverse_a: assert property (@(posedge sys_clk) disable iff (rst)
        outputPins == ~output_port_bits)
        else $error("output pins not inverted");
    irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        (masked_interrupt_status != 8'h00) == !irq_n)
        else $error("irq_n wrong for masked status");
    status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rdStatus |=> regRdData == $past(interrupt_status))
        else $error("status read wrong");
    masked_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        rdMasked |=> regRdData == $past(interrupt_status & interrupt_mask))
        else $error("masked read wrong");
    input_change_a: assert property (@(posedge sys_clk) disable iff (rst)
        pinEdge |=> interrupt_status[BIT_INPUT])
        else $error("input change not flagged");
    break_b_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        breakFlagB && !resetBreakB |=> breakFlagB)
        else $error("break flag dropped");
    tx_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        txReadyB && txAcceptB && txEnLastB && !txShiftLoadB |=> !txReadyB)
        else $error("tx ready not cleared");
    timer_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        counterRun && timerMode && stopCounter |=> counterRun)
        else $error("timer halted by stop");
    ct_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctSet |=> counterReady)
        else $error("counter ready not set");
    mask_all_a: assert property (@(posedge sys_clk) disable iff (rst)
        wrMask && regWrData == 8'hFF |=> interrupt_mask == 8'hFF)
        else $error("mask not written");

    irq_cov: cover property (@(posedge sys_clk) disable iff (rst) $fell(irq_n));
    start_cov: cover property (@(posedge sys_clk) disable iff (rst) rdCommand ##1 counterRun);
    setbits_cov: cover property (@(posedge sys_clk) disable iff (rst) wrCommand);
    masked_cov: cover property (@(posedge sys_clk) disable iff (rst) rdMasked && !irq_n);

endmodule // uart_irq_ctrl

`default_nettype wire

// ---- dv/host_model.sv ----
// host processor model: a bus master on the byte-wide register port
// assumes the slave answers a read in the cycle after the strobe, never stalls
`default_nettype none
module host_model
    import uart_irq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] regRdData,
    output var logic [3:0] regAddr,
    output var logic [7:0] regWrData,
    output var logic regWrite,
    output var logic regRead
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // idle bus at time zero
    initial
    begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrite = 1'h0;
        regRead = 1'h0;
    end
    // one write: strobe held for exactly one cycle, address and data left on the bus after it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'h1;
        @(posedge sys_clk);
        regWrite <= 1'h0;
    endtask
    // one read: data taken at the edge that closes the answer cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge sys_clk);
        regRead <= 1'h0;
        @(posedge sys_clk);
        d = regRdData;
    endtask
endmodule // host_model
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench of the interrupt control block
// assumes the host model for register traffic; event strobes come from here
`default_nettype none
`define CHK(nm, e, g) check(nm, 8'(e), 8'(g))
module testbench
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, regWrite, regRead, counterRun, counterStart;
    logic irq_n, eventIrq, txAcceptA, txAcceptB;
    logic [3:0] regAddr, inputPins;
    logic [7:0] regWrData, regRdData, outputPins, v;
    // per channel: 9 brk 8 rstBrk 7 fullMode 6 load 5 full 4 notEmpty 3 pop 2 txEn 1 hold 0 shift
    // index 2: 4 timerMode 3 zero 2 square 1 stop 0 readChange
    logic [9:0] evt [3];
    logic [1:0] acc;
    int errorCnt = 0;
    int nChecks = 0;
    int starts = 0;
    // ==========================================================
    // design and host
    uart_irq_ctrl u_uart_irq_ctrl (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .inputPins(inputPins),
        .breakEdgeA(evt[0][9]), .resetBreakA(evt[0][8]), .rxFullModeA(evt[0][7]),
        .rxLoadA(evt[0][6]), .rxFifoFullA(evt[0][5]), .rxNotEmptyA(evt[0][4]),
        .rxPopA(evt[0][3]), .txEnableA(evt[0][2]), .txHoldWriteA(evt[0][1]),
        .txShiftLoadA(evt[0][0]),
        .breakEdgeB(evt[1][9]), .resetBreakB(evt[1][8]), .rxFullModeB(evt[1][7]),
        .rxLoadB(evt[1][6]), .rxFifoFullB(evt[1][5]), .rxNotEmptyB(evt[1][4]),
        .rxPopB(evt[1][3]), .txEnableB(evt[1][2]), .txHoldWriteB(evt[1][1]),
        .txShiftLoadB(evt[1][0]),
        .timerMode(evt[2][4]), .counterZero(evt[2][3]), .squareWaveCycle(evt[2][2]),
        .stopCounter(evt[2][1]), .readInputChange(evt[2][0]),
        .counterRun(counterRun), .counterStart(counterStart), .outputPins(outputPins),
        .irq_n(irq_n), .eventIrq(eventIrq), .txAcceptA(txAcceptA), .txAcceptB(txAcceptB));
    host_model u_host_model (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
    // ==========================================================
    // helpers
    task automatic check(string nm, logic [7:0] e, logic [7:0] g);
        nChecks++;
        if (g !== e)
        begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // count counter start strobes as the design drives them at each edge
    always @(posedge sys_clk)
    begin
        if (counterStart)
            starts <= starts + 1;
    end
    // one-cycle strobe on an event input; tx accept sampled while it stands
    task automatic pulse(input int c, input int b);
        @(posedge sys_clk);
        evt[c][b] <= 1'h1;
        @(posedge sys_clk);
        acc = {txAcceptB, txAcceptA};
        evt[c][b] <= 1'h0;
    endtask
    task automatic stat(input int b, input logic e);
        u_host_model.rd(ADDR_STATUS_MASK, v);
        `CHK("status bit", e, v[b]);
    endtask
    task automatic test_done();
        if (errorCnt == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        @(negedge sys_clk);
        `CHK("pins", 8'hFF, outputPins);
        `CHK("irq", 1'h1, irq_n);
        u_host_model.rd(ADDR_VECTOR, v);
        `CHK("vector", RESET_VECTOR, v);
        u_host_model.wr(ADDR_VECTOR, 8'h5A);
        u_host_model.rd(ADDR_VECTOR, v);
        `CHK("vector", 8'h5A, v);
        u_host_model.rd(4'h3, v);
        `CHK("unmapped", 8'h00, v);
        u_host_model.rd(ADDR_STATUS_MASK, v);
        `CHK("status", 8'h00, v);
    endtask
    // set-only writes, then the start read that returns nothing
    task automatic t_outport();
        u_host_model.wr(ADDR_COMMAND_PORT, 8'h05);
        u_host_model.wr(ADDR_COMMAND_PORT, 8'h30);
        @(negedge sys_clk);
        `CHK("pins", 8'hCA, outputPins);
        u_host_model.rd(ADDR_COMMAND_PORT, v);
        `CHK("start read", 8'h00, v);
        `CHK("run", 1'h1, counterRun);
        `CHK("starts", 1, starts);
    endtask
    task automatic t_counter();
        pulse(2, 3);
        stat(BIT_COUNTER, 1'h1);
        pulse(2, 1);
        stat(BIT_COUNTER, 1'h0);
        `CHK("run", 1'h0, counterRun);
        evt[2][4] <= 1'h1;
        u_host_model.rd(ADDR_COMMAND_PORT, v);
        `CHK("start read", 8'h00, v);
        `CHK("starts", 2, starts);
        pulse(2, 2);
        stat(BIT_COUNTER, 1'h1);
        pulse(2, 1);
        stat(BIT_COUNTER, 1'h0);
        `CHK("run", 1'h1, counterRun);
        evt[2][4] <= 1'h0;
    endtask
    // transmit ready life cycle; a write while disabled is dropped
    task automatic t_tx(input int c);
        pulse(c, 1);
        `CHK("accept", 1'h0, acc[c]);
        evt[c][2] <= 1'h1;
        stat(4 * c, 1'h1);
        pulse(c, 1);
        `CHK("accept", 1'h1, acc[c]);
        stat(4 * c, 1'h0);
        pulse(c, 0);
        stat(4 * c, 1'h1);
        evt[c][2] <= 1'h0;
        stat(4 * c, 1'h0);
    endtask
    task automatic t_rx(input int c);
        evt[c][4] <= 1'h1;
        pulse(c, 6);
        stat(4 * c + 1, 1'h1);
        pulse(c, 3);
        stat(4 * c + 1, 1'h1);
        evt[c][4] <= 1'h0;
        pulse(c, 3);
        stat(4 * c + 1, 1'h0);
        evt[c][7] <= 1'h1;
        evt[c][4] <= 1'h1;
        pulse(c, 6);
        stat(4 * c + 1, 1'h0);
        evt[c][5] <= 1'h1;
        pulse(c, 6);
        stat(4 * c + 1, 1'h1);
        pulse(c, 3);
        stat(4 * c + 1, 1'h0);
        pulse(c, 6);
        stat(4 * c + 1, 1'h1);
        evt[c][5] <= 1'h0;
        evt[c][4] <= 1'h0;
        pulse(c, 3);
        evt[c][7] <= 1'h0;
    endtask
    task automatic t_input();
        u_host_model.wr(ADDR_PIN_SELECT, 8'h01);
        u_host_model.rd(ADDR_PIN_SELECT, v);
        `CHK("pin select", 8'h01, v);
        inputPins <= 4'h2;
        stat(BIT_INPUT, 1'h0);
        inputPins <= 4'h3;
        stat(BIT_INPUT, 1'h1);
        pulse(2, 0);
        stat(BIT_INPUT, 1'h0);
        u_host_model.wr(ADDR_STATUS_MASK, 8'h80);
        inputPins <= 4'h2;
        stat(BIT_INPUT, 1'h1);
        `CHK("irq", 1'h0, irq_n);
        pulse(2, 0);
        stat(BIT_INPUT, 1'h0);
        `CHK("irq", 1'h1, irq_n);
    endtask
    // both break flags up, then a table of masks
    task automatic t_mask();
        const logic [7:0] mk [3] = '{8'h04, 8'h80, 8'hFF};
        pulse(0, 9);
        pulse(1, 9);
        u_host_model.rd(ADDR_STATUS_MASK, v);
        `CHK("status", 8'h44, v);
        for (int i = 0; i < 3; i++)
        begin
            u_host_model.wr(ADDR_STATUS_MASK, mk[i]);
            u_host_model.rd(ADDR_MASKED_STATUS, v);
            `CHK("masked", mk[i] & 8'h44, v);
            `CHK("irq", (mk[i] & 8'h44) == 8'h00, irq_n);
        end
        pulse(0, 8);
        pulse(1, 8);
        u_host_model.rd(ADDR_MASKED_STATUS, v);
        `CHK("masked", 8'h00, v);
        `CHK("irq", 1'h1, irq_n);
    endtask
    // event interrupt: raise, mask, clear
    task automatic t_event();
        u_host_model.wr(ADDR_EVT_CLEAR, 8'h07);
        u_host_model.wr(ADDR_EVT_ENABLE, 8'h01);
        u_host_model.wr(ADDR_COMMAND_PORT, 8'h00);
        u_host_model.rd(ADDR_EVT_STATUS, v);
        `CHK("event status", 8'h01, v);
        `CHK("event irq", 1'h1, eventIrq);
        u_host_model.wr(ADDR_EVT_ENABLE, 8'h00);
        u_host_model.rd(ADDR_EVT_ENABLE, v);
        `CHK("event enable", 8'h00, v);
        `CHK("event irq", 1'h0, eventIrq);
        u_host_model.wr(ADDR_EVT_CLEAR, 8'h01);
        u_host_model.rd(ADDR_EVT_STATUS, v);
        `CHK("event status", 8'h00, v);
    endtask
    // ==========================================================
    // clock, watchdog, main sequence
    initial
    begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errorCnt++;
        test_done();
    end
    initial
    begin
        rst = 1'h1;
        inputPins = 4'h0;
        evt = '{10'h000, 10'h000, 10'h000};
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
        t_reset();
        t_outport();
        t_counter();
        t_tx(0);
        t_tx(1);
        t_rx(0);
        t_rx(1);
        t_input();
        t_mask();
        t_event();
        test_done();
    end
endmodule // testbench
`default_nettype wire
